// ===== rtl/scratchpad_regs.svh
// Register offsets, field positions and reset values of the scratchpad
`ifndef SCRATCHPAD_REGS_SVH
`define SCRATCHPAD_REGS_SVH
`define CONFIG_OFFSET       8'h44
`define RELOC_OFFSET        8'h48
`define CONFIG_RESET        32'h00000000
`define RELOC_RESET         32'hD1030000
`define CONFIG_MASK         32'h0000003F
`define RELOC_MASK          32'hFFFFC000
`define PRIO_BIT            0
`define SIZE_BIT            1
`define LOCK_LSB            2
`define RELOC_LSB           14
`define SLOT_CYCLES         2'h2
`define RAM_WORDS           4096
`define HALF_WORDS          2048
`define WORD_ADDR_BITS      12
`define HALF_ADDR_BITS      11
`endif

// ===== rtl/scratchpad_pkg.sv
// Types shared by the scratchpad design
`default_nettype none
package scratchpad_pkg;
  typedef enum logic [0:0] {
    owner_cpu,
    owner_sys
  } owner_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [13:0] addr;
    logic [3:0]  sel;
    logic [31:0] data;
  } mem_req_type;

  typedef struct packed {
    owner_type   owner;
    logic [1:0]  slot_left;
  } arb_type;
endpackage
`default_nettype wire

// ===== rtl/dual_port_scratchpad_ram.sv
// Dual-port 16 KB scratchpad RAM with arbitration, lock and trace mode
// Behaviour
// RULE_01 - 16 KB RAM, zero-wait processor port
// RULE_02 - System bus reads/writes without wait states
// RULE_03 - Round-robin per half on collision
// RULE_04 - Grants last two cycles, may idle
// RULE_05 - Halves independent, cross accesses concurrent
// RULE_06 - Base relocatable in 16 KB steps
// RULE_07 - Software avoids overlapping relocation
// RULE_08 - Four 4 KB areas lockable from system bus
// RULE_09 - Lock bit n guards area n
// RULE_10 - Size bit selects trace mode
// RULE_11 - Trace mode: upper half for tracer only
// RULE_12 - Precedence bit selects scratchpad alias winner
// RULE_13 - Configuration resets to zero
// RULE_14 - Base resets to its default address
// RULE_15 - Lock ignores processor writes; the code ignores system-bus writes instead
// RULE_16 - Lone requester granted at once
`timescale 1ns/1ns
`default_nettype none
`include "scratchpad_regs.svh"

module dual_port_scratchpad_ram (
  input  wire logic        clock_in,         // System clock 10 MHz
  input  wire logic        rstn_in,          // Synchronous reset, low
  // Processor local bus
  input  wire logic        cpu_req_in,       // Access request
  input  wire logic        cpu_we_in,        // Write
  input  wire logic [13:0] cpu_addr_in,      // Byte offset in RAM
  input  wire logic [3:0]  cpu_sel_in,       // Byte enables
  input  wire logic [31:0] cpu_wdata_in,     // Write data
  output logic             cpu_ready_out,    // Access taken this cycle
  output logic [31:0]      cpu_rdata_out,    // Read data, next cycle
  // System bus memory port
  input  wire logic        sys_req_in,       // Access request
  input  wire logic        sys_we_in,        // Write
  input  wire logic [13:0] sys_addr_in,      // Byte offset in RAM
  input  wire logic [3:0]  sys_sel_in,       // Byte enables
  input  wire logic [31:0] sys_wdata_in,     // Write data
  output logic             sys_ready_out,    // Access taken this cycle
  output logic [31:0]      sys_rdata_out,    // Read data, next cycle
  // Trace capture into upper half
  input  wire logic        trace_we_in,      // Trace word write
  input  wire logic [10:0] trace_addr_in,    // Word in upper half
  input  wire logic [31:0] trace_data_in,    // Trace word
  // Wishbone register slave
  input  wire logic        wb_cyc_i,         // Cycle
  input  wire logic        wb_stb_i,         // Strobe
  input  wire logic        wb_we_i,          // Write enable
  input  wire logic [7:0]  wb_adr_i,         // Byte address
  input  wire logic [3:0]  wb_sel_i,         // Byte lanes
  input  wire logic [31:0] wb_dat_i,         // Write data
  output logic [31:0]      wb_dat_o,         // Read data
  output logic             wb_ack_o,         // Acknowledge
  // Configuration outputs to the address decoder
  output logic [31:0]      ram_base_out,     // Current base address
  output logic             alias_precedence_bit_out, // 1: RAM alias wins
  output logic             trace_mode_out    // Upper half is trace
);

  typedef struct packed {
    logic [31:0]                 config_reg;
    logic [31:0]                 reloc_reg;
    logic [31:0]                 wb_rdata;
    logic                        wb_ack;
    scratchpad_pkg::arb_type     arb_lo;
    scratchpad_pkg::arb_type     arb_hi;
    logic [31:0]                 cpu_rdata;
    logic [31:0]                 sys_rdata;
  } state_type;

  state_type state;
  state_type next_state;

  logic [31:0] mem [0:`RAM_WORDS-1];

  scratchpad_pkg::mem_req_type cpu_req;
  scratchpad_pkg::mem_req_type sys_req;

  // Half select from byte offset bit 13
  function automatic logic half_of(input logic [13:0] a);
    half_of = a[13];
  endfunction

  // Byte-lane merge used by both ports
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // Round-robin step for one half; returns owner granted this cycle
  function automatic logic grant_sys(input scratchpad_pkg::arb_type a,
                                     input logic c, input logic s);
    if (c && s) begin
      grant_sys = (a.owner == scratchpad_pkg::owner_sys); // [RULE_03]
    end else begin
      grant_sys = s; // [RULE_16]
    end
  endfunction

  logic trace_mode;
  logic cpu_hi_blocked;
  logic sys_hi_blocked;
  logic cpu_want_lo;
  logic cpu_want_hi;
  logic sys_want_lo;
  logic sys_want_hi;
  logic gs_lo;
  logic gs_hi;
  logic cpu_go;
  logic sys_go;
  logic sys_locked;
  logic cpu_wr;
  logic sys_wr;
  logic wb_hit;

  assign cpu_req = '{cpu_req_in, cpu_we_in, cpu_addr_in, cpu_sel_in,
                     cpu_wdata_in};
  assign sys_req = '{sys_req_in, sys_we_in, sys_addr_in, sys_sel_in,
                     sys_wdata_in};

  assign trace_mode = state.config_reg[`SIZE_BIT]; // [RULE_10]
  // Application ports see only the lower half in trace mode
  assign cpu_hi_blocked = trace_mode && half_of(cpu_req.addr); // [RULE_11]
  assign sys_hi_blocked = trace_mode && half_of(sys_req.addr); // [RULE_11]

  assign cpu_want_lo = cpu_req.valid && !half_of(cpu_req.addr);
  assign cpu_want_hi = cpu_req.valid && half_of(cpu_req.addr)
                       && !cpu_hi_blocked;
  assign sys_want_lo = sys_req.valid && !half_of(sys_req.addr);
  assign sys_want_hi = sys_req.valid && half_of(sys_req.addr)
                       && !sys_hi_blocked;

  // Each half has its own arbiter, so cross-half traffic never stalls
  assign gs_lo = grant_sys(state.arb_lo, cpu_want_lo, sys_want_lo); // [RULE_05]
  assign gs_hi = grant_sys(state.arb_hi, cpu_want_hi, sys_want_hi); // [RULE_05]

  assign cpu_go = (cpu_want_lo && !gs_lo) || (cpu_want_hi && !gs_hi);
  assign sys_go = (sys_want_lo && gs_lo) || (sys_want_hi && gs_hi);

  // Blocked trace-mode accesses still complete so the bus cannot hang
  assign cpu_ready_out = cpu_go || (cpu_req.valid && cpu_hi_blocked); // [RULE_01]
  assign sys_ready_out = sys_go || (sys_req.valid && sys_hi_blocked); // [RULE_02]

  assign sys_locked = state.config_reg[`LOCK_LSB + sys_req.addr[13:12]]; // [RULE_08] [RULE_09]
  assign cpu_wr = cpu_go && cpu_req.write; // [RULE_15]
  assign sys_wr = sys_go && sys_req.write && !sys_locked; // [RULE_15]

  assign wb_hit = wb_cyc_i && wb_stb_i && !state.wb_ack;

  // Arbiter slot update for one half
  function automatic scratchpad_pkg::arb_type arb_next(
      input scratchpad_pkg::arb_type a, input logic c, input logic s,
      input logic gs);
    scratchpad_pkg::arb_type n;
    n = a;
    if (c && s) begin
      // A slot is two cycles, spent even if its holder idles
      if (a.slot_left == 2'h1) begin // [RULE_04]
        n.owner = (a.owner == scratchpad_pkg::owner_cpu) ?
                  scratchpad_pkg::owner_sys : scratchpad_pkg::owner_cpu;
        n.slot_left = `SLOT_CYCLES;
      end else begin
        n.slot_left = a.slot_left - 2'h1;
      end
    end else if (c || s) begin
      // Lone user owns the slot; the other side gets the next one
      n.owner = gs ? scratchpad_pkg::owner_sys : scratchpad_pkg::owner_cpu;
      n.slot_left = `SLOT_CYCLES - 2'h1;
    end else if (a.slot_left != `SLOT_CYCLES) begin
      n.slot_left = a.slot_left - 2'h1; // [RULE_04]
      if (a.slot_left == 2'h1) begin
        n.owner = (a.owner == scratchpad_pkg::owner_cpu) ?
                  scratchpad_pkg::owner_sys : scratchpad_pkg::owner_cpu;
        n.slot_left = `SLOT_CYCLES;
      end
    end
    arb_next = n;
  endfunction

  always_comb begin
    next_state = state;
    next_state.arb_lo = arb_next(state.arb_lo, cpu_want_lo, sys_want_lo,
                                 gs_lo);
    next_state.arb_hi = arb_next(state.arb_hi, cpu_want_hi, sys_want_hi,
                                 gs_hi);
    next_state.cpu_rdata = cpu_go ? mem[cpu_req.addr[13:2]] : 32'h00000000;
    next_state.sys_rdata = sys_go ? mem[sys_req.addr[13:2]] : 32'h00000000;
    next_state.wb_ack = wb_hit;
    next_state.wb_rdata = 32'h00000000;
    if (wb_hit) begin
      if (wb_adr_i == `CONFIG_OFFSET) begin
        next_state.wb_rdata = state.config_reg;
        if (wb_we_i) begin
          next_state.config_reg = merge(state.config_reg, wb_dat_i,
                                        wb_sel_i) & `CONFIG_MASK;
        end
      end else if (wb_adr_i == `RELOC_OFFSET) begin
        next_state.wb_rdata = state.reloc_reg;
        if (wb_we_i) begin
          // Low bits reserved: base moves only in 16 KB steps
          next_state.reloc_reg = merge(state.reloc_reg, wb_dat_i,
                                       wb_sel_i) & `RELOC_MASK; // [RULE_06]
        end
      end
    end
    if (!rstn_in) begin
      next_state = '0;
      next_state.config_reg = `CONFIG_RESET; // [RULE_13]
      next_state.reloc_reg = `RELOC_RESET; // [RULE_14]
      next_state.arb_lo.slot_left = `SLOT_CYCLES;
      next_state.arb_hi.slot_left = `SLOT_CYCLES;
    end
  end

  always_ff @(posedge clock_in) begin
    state <= next_state;
  end

  // Two writers can hit the same word only if arbitration failed;
  // the halves guarantee at most one application writer per half.
  always_ff @(posedge clock_in) begin
    if (cpu_wr) begin
      mem[cpu_req.addr[13:2]] <= merge(mem[cpu_req.addr[13:2]],
                                       cpu_req.data, cpu_req.sel);
    end
    if (sys_wr) begin
      mem[sys_req.addr[13:2]] <= merge(mem[sys_req.addr[13:2]],
                                       sys_req.data, sys_req.sel);
    end
    if (trace_we_in && trace_mode) begin
      mem[{1'h1, trace_addr_in}] <= trace_data_in; // [RULE_11]
    end
  end

  assign cpu_rdata_out = state.cpu_rdata;
  assign sys_rdata_out = state.sys_rdata;
  assign wb_dat_o = state.wb_rdata;
  assign wb_ack_o = state.wb_ack;
  assign ram_base_out = state.reloc_reg; // [RULE_06]
  assign alias_precedence_bit_out = state.config_reg[`PRIO_BIT]; // [RULE_12]
  assign trace_mode_out = trace_mode;

endmodule // dual_port_scratchpad_ram
`default_nettype wire

// ===== dv/dual_port_scratchpad_ram_asserts.sv
// Port assertions for the dual-port scratchpad
`timescale 1ns/1ns
`default_nettype none
module scratchpad_chk (
  input wire logic        clock_in, rstn_in, cpu_req_in, sys_req_in,
  input wire logic        cpu_ready_out, sys_ready_out, wb_cyc_i, wb_stb_i,
  input wire logic        wb_we_i, wb_ack_o, trace_mode_out,
  input wire logic        alias_precedence_bit_out,
  input wire logic [13:0] cpu_addr_in, sys_addr_in,
  input wire logic [31:0] ram_base_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  wire logic both = cpu_req_in && sys_req_in;
  wire logic same = both && cpu_addr_in[13] == sys_addr_in[13];
  property p_lone;
    (cpu_req_in && !sys_req_in |-> cpu_ready_out) and
    (sys_req_in && !cpu_req_in |-> sys_ready_out); endproperty
  a_lone: assert property (p_lone) else $error("lone stall");
  property p_split; both && !same |-> cpu_ready_out && sys_ready_out;
  endproperty
  a_split: assert property (p_split) else $error("halves stall");
  property p_excl; same |-> cpu_ready_out != sys_ready_out; endproperty
  a_excl: assert property (p_excl) else $error("bad grant");
  property p_alt; (same && cpu_ready_out) [*2] ##1 same |-> sys_ready_out;
  endproperty
  a_alt: assert property (p_alt) else $error("no rotation");
  property p_hold; same && sys_ready_out && $past(same && cpu_ready_out)
    ##1 same |-> sys_ready_out; endproperty
  a_hold: assert property (p_hold) else $error("slot cut");
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_rst; $rose(rstn_in) |-> ram_base_out == 32'hD1030000 &&
    !trace_mode_out && !alias_precedence_bit_out; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_keep; !(wb_cyc_i && wb_stb_i && wb_we_i) |=>
    $stable(ram_base_out); endproperty
  a_keep: assert property (p_keep) else $error("base moved");
endmodule // scratchpad_chk
bind dual_port_scratchpad_ram scratchpad_chk scratchpad_chk_inst (
  .clock_in, .rstn_in, .cpu_req_in, .sys_req_in, .cpu_ready_out,
  .sys_ready_out, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .trace_mode_out,
  .alias_precedence_bit_out, .cpu_addr_in, .sys_addr_in, .ram_base_out);
`default_nettype wire

// ===== dv/dma_model.sv
// System-bus master model driving the scratchpad's DMA port
`timescale 1ns/1ns
`default_nettype none
module dma_model (
  input  wire logic   clock_in,  // System clock
  input  wire logic   ready_in,  // Port grant
  output logic        req_out,   // Request
  output logic        we_out,    // Write
  output logic [13:0] addr_out,  // Byte offset
  output logic [3:0]  sel_out,   // Byte lanes
  output logic [31:0] data_out   // Write data
);
  int errs;
  initial begin
    {req_out, we_out, addr_out, data_out, errs} = '0;
    sel_out = 4'hF;
  end
  // Idle cycles before the burst give slow answers
  task automatic xfer(input logic w, input logic [13:0] a,
                      input logic [31:0] d, input int idle = 0, cnt = 1);
    int n;
    repeat (idle) @(posedge clock_in);
    for (int i = 0; i < cnt; i++) begin
      {req_out, we_out, addr_out, data_out} <= {1'h1, w, a + 14'(i << 2), d};
      n = 0;
      do @(posedge clock_in); while (!ready_in && ++n < 64);
      if (!ready_in) errs++;
    end
    // Released lines carry junk so stale data never passes for valid
    {req_out, addr_out, data_out} <= {1'h0, ~a, ~d};
    @(posedge clock_in);
  endtask
endmodule // dma_model
`default_nettype wire

// ===== dv/dual_port_scratchpad_ram_tb.sv
// Self-checking bench for the dual-port scratchpad
`timescale 1ns/1ns
`default_nettype none
module dual_port_scratchpad_ram_tb;
  logic        clock_in, rstn_in, cpu_req_in, cpu_we_in, cpu_ready_out;
  logic        sys_req_in, sys_we_in, sys_ready_out, trace_we_in, cpend;
  logic        spend;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, trace_mode_out, prio;
  logic [13:0] cpu_addr_in, sys_addr_in;
  logic [3:0]  cpu_sel_in, sys_sel_in;
  logic [10:0] trace_addr_in;
  logic [7:0]  wb_adr_i;
  logic [31:0] cpu_wdata_in, cpu_rdata_out, sys_wdata_in, sys_rdata_out;
  logic [31:0] trace_data_in, wb_dat_i, wb_dat_o, ram_base_out, d0, d1;
  logic [31:0] wq[$], cq[$], sq[$];
  int          bad_count, total_checks;
  dual_port_scratchpad_ram dual_port_scratchpad_ram_inst (
    .clock_in, .rstn_in, .cpu_req_in, .cpu_we_in, .cpu_addr_in, .cpu_sel_in,
    .cpu_wdata_in, .cpu_ready_out, .cpu_rdata_out, .sys_req_in, .sys_we_in,
    .sys_addr_in, .sys_sel_in, .sys_wdata_in, .sys_ready_out, .sys_rdata_out,
    .trace_we_in, .trace_addr_in, .trace_data_in, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .ram_base_out, .alias_precedence_bit_out(prio), .trace_mode_out);
  dma_model dma_model_inst (.clock_in, .ready_in(sys_ready_out),
    .req_out(sys_req_in), .we_out(sys_we_in), .addr_out(sys_addr_in),
    .sel_out(sys_sel_in), .data_out(sys_wdata_in));
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    if (ok !== 1'h1) begin
      chk("handshake", ok, 32'h1);
      finish_test;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    if (!w) wq.push_back(d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do @(posedge clock_in); while (!wb_ack_o && ++n < 20);
    tmo(wb_ack_o);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clock_in);
  endtask
  task automatic cpu(input logic w, input logic [13:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF, input logic last = 1'h1);
    int n = 0;
    if (!w) cq.push_back(d);
    {cpu_req_in, cpu_we_in, cpu_sel_in, cpu_addr_in} <= {1'h1, w, s, a};
    cpu_wdata_in <= d;
    do @(posedge clock_in); while (!cpu_ready_out && ++n < 20);
    tmo(cpu_ready_out);
    if (last) cpu_req_in <= 1'h0;
    if (last) @(posedge clock_in);
  endtask
  always @(posedge clock_in) begin
    if (cpend) chk("cpu", cpu_rdata_out, cq.pop_front());
    cpend = cpu_req_in && cpu_ready_out && !cpu_we_in;
    if (spend) chk("sys", sys_rdata_out, sq.pop_front());
    spend = sys_req_in && sys_ready_out && !sys_we_in;
    if (wb_ack_o && !wb_we_i)
      chk("reg", wb_dat_o, wq.pop_front());
  end
  initial begin
    clock_in = 1'h0;
    forever #50 clock_in = ~clock_in;
  end
  initial begin
    {rstn_in, cpu_req_in, cpu_we_in, trace_we_in, cpend, spend} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {cpu_addr_in, cpu_sel_in, cpu_wdata_in, trace_addr_in, trace_data_in} = '0;
    {bad_count, total_checks} = '0;
    d0 = $urandom(47038);
    repeat (6) @(posedge clock_in);
    rstn_in <= 1'h1;
    @(posedge clock_in);
    wb(1'h0, 8'h44, 32'h0);
    wb(1'h0, 8'h48, 32'hD1030000);
    $display("test reset values done");
    wb(1'h1, 8'h44, 32'hFFFFFFFF);
    wb(1'h0, 8'h44, 32'h0000003F);
    chk("precedence", prio, 32'h1);
    // Base stays in a window kept free for it
    d0 = 32'hD1000000 | ($urandom & 32'h000FFFFF);
    wb(1'h1, 8'h48, d0);
    wb(1'h0, 8'h48, d0 & 32'hFFFFC000);
    chk("base", ram_base_out, d0 & 32'hFFFFC000);
    wb(1'h1, 8'h4C, d0);
    wb(1'h0, 8'h4C, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      d0 = $urandom;
      d1 = ~d0;
      wb(1'h1, 8'h44, 32'h4 << k);
      cpu(1'h1, 14'(k << 12), d0);
      dma_model_inst.xfer(1'h1, 14'(k << 12), d1, k);
      cpu(1'h0, 14'(k << 12), d0);
      cpu(1'h1, 14'(k << 12), d1);
      cpu(1'h0, 14'(k << 12), d1);
      dma_model_inst.xfer(1'h1, 14'(((k + 1) % 4) << 12), d0);
      cpu(1'h0, 14'(((k + 1) % 4) << 12), d0);
      sq.push_back(d1);
      dma_model_inst.xfer(1'h0, 14'(k << 12), 32'h0);
    end
    wb(1'h1, 8'h44, 32'h0);
    $display("test write lock done");
    fork
      for (int i = 0; i < 4; i++) cpu(1'h1, 14'(i << 2), d0, 4'hF, i == 3);
      dma_model_inst.xfer(1'h1, 14'h0400, d1, 0, 6);
    join
    cpu(1'h0, 14'h0414, d1);
    cpu(1'h0, 14'h000C, d0);
    fork
      for (int i = 0; i < 3; i++) cpu(1'h0, 14'h0004, d0, 4'hF, i == 2);
      dma_model_inst.xfer(1'h1, 14'h2000, d1, 0, 3);
    join
    cpu(1'h0, 14'h2008, d1);
    cpu(1'h1, 14'h0010, d0);
    cpu(1'h1, 14'h0010, d1, 4'h3);
    cpu(1'h0, 14'h0010, {d0[31:16], d1[15:0]});
    $display("test arbitration done");
    wb(1'h1, 8'h44, 32'h2);
    chk("trace mode", trace_mode_out, 32'h1);
    // Word 2 of the upper half is kept clear for the blocked-write check
    {trace_we_in, trace_addr_in, trace_data_in} <=
      {1'h1, 11'($urandom) | 11'h004, $urandom};
    @(posedge clock_in);
    trace_we_in <= 1'h0;
    cpu(1'h1, 14'h2008, d0);
    cpu(1'h0, 14'h2008, 32'h0);
    cpu(1'h0, 14'h0010, {d0[31:16], d1[15:0]});
    wb(1'h1, 8'h44, 32'h0);
    cpu(1'h0, 14'({1'h1, trace_addr_in, 2'h0}), trace_data_in);
    cpu(1'h0, 14'h2008, d1);
    $display("test trace mode done");
    chk("dma waits", dma_model_inst.errs, 32'h0);
    finish_test;
  end
endmodule // dual_port_scratchpad_ram_tb
`default_nettype wire
